// ---- bench/sos_env.sv ----
// Model of the controller core around the selector: input, output and
// function block levels. Assumes one level raised at a time by kind/sel.
`timescale 1ns/1ps
module sos_env
   import sos_pkg::*;
(
   input  wire logic        clk,
   input  wire logic [3:0]  kind,
   input  wire logic [2:0]  sel,
   input  wire logic        on,
   input  wire logic [7:0]  run_mask,
   output logic [N_SI-1:0]  in_run,
   output logic [N_SI-1:0]  in_settled,
   output logic [N_SI-1:0]  in_bypassed,
   output logic [N_SI-1:0]  in_muted,
   output logic [N_SI-1:0]  in_mute_ovr,
   output logic [N_SI-1:0]  in_fault,
   output logic [N_SI-1:0]  mute_cyc_act,
   output logic [N_SI-1:0]  mute_sens_blk,
   output logic [N_SO-1:0]  so_on_dly,
   output logic [N_SO-1:0]  so_off_dly,
   output logic [N_SO-1:0]  so_on,
   output logic [N_SO-1:0]  so_fault,
   output logic [N_SO-1:0]  so_logic,
   output logic [N_FB-1:0]  fb_run,
   output logic [N_RST-1:0] rst_pending,
   output logic             sys_lockout
);
   logic [7:0] hot;
   logic [7:0] run_q = 8'h00;
   logic [1:0] fcnt_q = 2'h0;
   assign hot = on ? 8'(8'h01 << sel) : 8'h00;
   always_ff @(posedge clk) begin
      in_bypassed   <= (kind == 4'h0) ? hot : 8'h00;
      in_muted      <= (kind == 4'h1) ? hot : 8'h00;
      in_mute_ovr   <= (kind == 4'h2) ? hot : 8'h00;
      in_fault      <= (kind == 4'h3) ? hot : 8'h00;
      run_q         <= run_mask | ((kind == 4'h4) ? hot : 8'h00);
      in_run        <= run_q;
      if (run_q != in_run) begin
         fcnt_q <= 2'h3;
      end else if (fcnt_q != 2'h0) begin
         fcnt_q <= fcnt_q - 2'h1;
      end
      // Settled drops with each change and rises after filtering.
      in_settled    <= (fcnt_q == 2'h0 && run_q == in_run) ? 8'hFF : 8'h00;
      mute_cyc_act  <= 8'h00;
      mute_sens_blk <= (kind == 4'hD) ? hot : 8'h00;
      so_on_dly     <= (kind == 4'h5) ? hot[3:0] : 4'h0;
      so_off_dly    <= (kind == 4'h6) ? hot[3:0] : 4'h0;
      so_on         <= (kind == 4'h7) ? hot[3:0] : 4'h0;
      so_fault      <= (kind == 4'h8) ? hot[3:0] : 4'h0;
      so_logic      <= (kind == 4'h9) ? hot[3:0] : 4'h0;
      fb_run        <= (kind == 4'hA) ? hot : 8'h00;
      rst_pending   <= (kind == 4'hB) ? hot[3:0] : 4'h0;
      sys_lockout   <= (kind == 4'hC) && on;
   end
endmodule

// ---- bench/test_status_output_selector.sv ----
// Testbench of the status output selector: reset and lockout, then
// table of functions, polarity, flashing, group latch, table size and chain.
// Assumes the environment model drives the controller state levels.
`timescale 1ns/1ps
module test_status_output_selector
   import sos_pkg::*;
;
   typedef struct packed {
      logic [3:0] fn;
      logic [2:0] csel;
      logic [3:0] kind;
      logic [2:0] ssel;
      logic       exp;
   } sos_row_t;
   logic clk, sys_rst, avs_read, avs_write, avs_waitrequest;
   logic sys_lockout, lockout, on;
   logic [11:0] avs_address;
   logic [3:0] avs_byteenable, kind;
   logic [31:0] avs_writedata, avs_readdata, q, cfg;
   logic [7:0] in_run, in_settled, in_bypassed, in_muted, in_mute_ovr;
   logic [7:0] in_fault, mute_cyc_act, mute_sens_blk, fb_run, run_mask;
   logic [3:0] so_on_dly, so_off_dly, so_on, so_fault, so_logic;
   logic [3:0] rst_pending, term_level, status_out;
   logic [2:0] group_rearm, sel;
   logic [15:0][15:0] chain_status;
   logic [2:0][15:0] dev_admin;
   logic [17:0][7:0] dev_data;
   int miscompares, cmp_count, cycles, k, hi;
   sos_row_t rows [18] = '{
      '{4'h1, 3'h3, 4'h0, 3'h3, 1'b1}, '{4'h1, 3'h3, 4'h0, 3'h4, 1'b0},
      '{4'h2, 3'h5, 4'h1, 3'h5, 1'b1}, '{4'h2, 3'h2, 4'h2, 3'h2, 1'b1},
      '{4'h3, 3'h1, 4'h5, 3'h1, 1'b1}, '{4'h3, 3'h2, 4'h6, 3'h2, 1'b1},
      '{4'h4, 3'h6, 4'h4, 3'h6, 1'b1}, '{4'h5, 3'h7, 4'h3, 3'h7, 1'b1},
      '{4'h5, 3'h7, 4'h3, 3'h6, 1'b0}, '{4'h6, 3'h0, 4'h3, 3'h4, 1'b1},
      '{4'h8, 3'h3, 4'h7, 3'h3, 1'b1}, '{4'h9, 3'h0, 4'h8, 3'h0, 1'b1},
      '{4'hA, 3'h0, 4'h8, 3'h2, 1'b1}, '{4'hB, 3'h1, 4'h9, 3'h1, 1'b1},
      '{4'hB, 3'h1, 4'h7, 3'h1, 1'b0}, '{4'hC, 3'h5, 4'hA, 3'h5, 1'b1},
      '{4'hD, 3'h3, 4'hB, 3'h3, 1'b1}, '{4'hE, 3'h0, 4'hC, 3'h0, 1'b1}};

   sos_top #(.VSO_LAT_CYC_P(1000), .OTHER_LAT_CYC_P(1000)) u_sos_top (
      .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .in_run(in_run), .in_settled(in_settled), .in_bypassed(in_bypassed),
      .in_muted(in_muted), .in_mute_ovr(in_mute_ovr), .in_fault(in_fault),
      .mute_cyc_act(mute_cyc_act), .mute_sens_blk(mute_sens_blk),
      .so_on_dly(so_on_dly), .so_off_dly(so_off_dly), .so_on(so_on),
      .so_fault(so_fault), .so_logic(so_logic), .fb_run(fb_run),
      .rst_pending(rst_pending), .sys_lockout(sys_lockout),
      .term_level(term_level), .group_rearm(group_rearm),
      .chain_status(chain_status), .dev_admin(dev_admin),
      .dev_data(dev_data), .status_out(status_out), .lockout(lockout));

   sos_env u_sos_env (
      .clk(clk), .kind(kind), .sel(sel), .on(on), .run_mask(run_mask),
      .in_run(in_run), .in_settled(in_settled), .in_bypassed(in_bypassed),
      .in_muted(in_muted), .in_mute_ovr(in_mute_ovr), .in_fault(in_fault),
      .mute_cyc_act(mute_cyc_act), .mute_sens_blk(mute_sens_blk),
      .so_on_dly(so_on_dly), .so_off_dly(so_off_dly), .so_on(so_on),
      .so_fault(so_fault), .so_logic(so_logic), .fb_run(fb_run),
      .rst_pending(rst_pending), .sys_lockout(sys_lockout));

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // One Avalon transfer; read data lands in q.
   task automatic bus(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      // Waitrequest is looked at mid-cycle, where it has settled.
      @(negedge clk);
      while (avs_waitrequest !== 1'b0 && n < 20) begin
         @(negedge clk);
         n++;
      end
      if (n == 20) miscompares++;
      q = avs_readdata;
      @(posedge clk);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic complete_run;
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         complete_run();
      end
   end

   initial begin
      sys_rst = 1'b1;
      {avs_read, avs_write, on, kind, sel} = '0;
      {avs_address, avs_writedata, run_mask, term_level, group_rearm} = '0;
      avs_byteenable = 4'hF;
      for (int i = 0; i < 16; i++) chain_status[i] = 16'h1000 + 16'(i);
      for (int i = 0; i < 3; i++) dev_admin[i] = 16'h00A0 + 16'(i);
      for (int i = 0; i < 18; i++) dev_data[i] = 8'h40 + 8'(i);
      tick(20);
      sys_rst <= 1'b0;
      tick(1);
      chk("out", {27'h0, lockout, status_out}, 32'h0);
      bus(1'b0, A_CTRL, 32'h0);
      chk("ctrl", q, 32'h0);
      bus(1'b0, A_FDIV, 32'h0);
      chk("fdiv", q, {5'h0, FDIV_RST});
      bus(1'b0, 12'h300, 32'h0);
      chk("unmapped", q, 32'h0);
      term_level <= 4'h4;
      tick(4);
      chk("spare", {31'h0, lockout}, 32'h1);
      bus(1'b1, A_PCFG + 12'h008, 32'h1);
      tick(4);
      chk("used", {31'h0, lockout}, 32'h0);
      term_level <= 4'h0;
      for (int i = 0; i < 18; i++) begin
         k = i % 4;
         cfg = {25'h0, rows[i].csel, rows[i].fn};
         bus(1'b1, A_PCFG + 12'(4 * k), cfg);
         bus(1'b1, A_VCFG + 12'(4 * i), cfg);
         kind <= rows[i].kind;
         sel <= rows[i].ssel;
         tick(12);
         chk("idle", {31'h0, status_out[k]}, 32'h0);
         on <= 1'b1;
         tick(12);
         chk("act", {31'h0, status_out[k]}, {31'h0, rows[i].exp});
         tick(300);
         bus(1'b0, A_VSTAT, 32'h0);
         chk("virt", {31'h0, q[i]}, {31'h0, rows[i].exp});
         on <= 1'b0;
      end
      bus(1'b1, A_PCFG, 32'h1000);
      tick(4);
      chk("pol", {31'h0, status_out[0]}, 32'h1);
      bus(1'b1, A_FDIV, 32'h3);
      bus(1'b1, A_PCFG, 32'h2);
      bus(1'b1, A_VCFG, 32'h2);
      kind <= 4'hD;
      sel <= 3'h0;
      on <= 1'b1;
      tick(12);
      hi = 0;
      repeat (32) begin
         @(posedge clk);
         hi += int'(status_out[0] === 1'b1);
      end
      chk("flash", 32'(hi), 32'd16);
      tick(300);
      bus(1'b0, A_VSTAT, 32'h0);
      chk("vflash", {31'h0, q[0]}, 32'h0);
      on <= 1'b0;
      kind <= 4'h4;
      bus(1'b1, A_GRP, 32'h0F);
      bus(1'b1, A_PCFG, 32'h27);
      run_mask <= 8'h0F;
      tick(12);
      run_mask <= 8'h0B;
      tick(12);
      run_mask <= 8'h09;
      tick(12);
      bus(1'b0, A_GRP, 32'h0);
      chk("first", {28'h0, q[19:16]}, 32'hA);
      chk("grp", {31'h0, status_out[0]}, 32'h1);
      group_rearm <= 3'h1;
      tick(3);
      group_rearm <= 3'h0;
      bus(1'b0, A_GRP, 32'h0);
      chk("rearm", {31'h0, q[19]}, 32'h0);
      bus(1'b1, A_VCFG + 12'h190, 32'hE);
      kind <= 4'hC;
      on <= 1'b1;
      tick(300);
      bus(1'b0, A_VSTAT + 12'h00C, 32'h0);
      chk("small", {31'h0, q[4]}, 32'h0);
      bus(1'b1, A_CTRL, 32'h1);
      tick(300);
      bus(1'b0, A_VSTAT + 12'h00C, 32'h0);
      chk("large", {31'h0, q[4]}, 32'h1);
      on <= 1'b0;
      bus(1'b0, A_CHAIN + 12'h03C, 32'h0);
      chk("chain", {16'h0, q[15:0]}, 32'h100F);
      bus(1'b0, A_ADMIN + 12'h008, 32'h0);
      chk("admin", {16'h0, q[15:0]}, 32'h00A2);
      bus(1'b0, A_DDATA + 12'h010, 32'h0);
      chk("ddata", {16'h0, q[15:0]}, 32'h5150);
      complete_run();
   end
endmodule

// ---- src/sos_pkg.sv ----
// Constants, types and register map of the status output selector.
// Assumes a single 125 MHz clock and byte addresses on the register bus.
package sos_pkg;

   localparam int N_PHYS       = 4;
   localparam int N_VIRT       = 256;
   localparam int N_VIRT_SMALL = 64;
   localparam int N_SI         = 8;
   localparam int N_SO         = 4;
   localparam int N_FB         = 8;
   localparam int N_RST        = 4;
   localparam int N_GRP        = 3;
   localparam int CHAIN_WORDS  = 16;
   localparam int DEV_ADMIN    = 3;
   localparam int DEV_BYTES    = 18;
   localparam int CFG_W        = 12;
   localparam int FDIV_W       = 27;

   localparam int CLK_MHZ       = 125;
   localparam int VSO_LAT_MS    = 100;
   localparam int OTHER_LAT_MS  = 1000;
   localparam int VSO_LAT_CYC   = VSO_LAT_MS * CLK_MHZ * 1000;
   localparam int OTHER_LAT_CYC = OTHER_LAT_MS * CLK_MHZ * 1000;

   localparam logic [FDIV_W-1:0] FDIV_RST = 27'h3B9ACA0;

   localparam int F_FN  = 0;
   localparam int F_SEL = 4;
   localparam int F_GRP = 7;
   localparam int F_POL = 12;

   localparam logic [11:0] A_CTRL  = 12'h000;
   localparam logic [11:0] A_FDIV  = 12'h004;
   localparam logic [11:0] A_STAT  = 12'h008;
   localparam logic [11:0] A_PCFG  = 12'h010;
   localparam logic [11:0] A_GRP   = 12'h020;
   localparam logic [11:0] A_VSTAT = 12'h040;
   localparam logic [11:0] A_CHAIN = 12'h080;
   localparam logic [11:0] A_ADMIN = 12'h0C0;
   localparam logic [11:0] A_DDATA = 12'h0E0;
   localparam logic [11:0] A_VCFG  = 12'h400;

   typedef enum logic [3:0] {
      FN_NONE, FN_BYPASS, FN_MUTE, FN_DELAY, FN_TRK_IN, FN_IN_FLT,
      FN_ANY_IN_FLT, FN_GROUP, FN_TRK_OUT, FN_OUT_FLT, FN_OUT_FLT_ALL,
      FN_OUT_LOGIC, FN_FB, FN_RST_WAIT, FN_LOCKOUT
   } sos_fn_t;

   typedef struct packed {
      logic                           wait_r;
      logic [31:0]                    rdata;
      logic                           v256;
      logic [FDIV_W-1:0]              fdiv;
      logic [FDIV_W-1:0]              fcnt;
      logic                           fph;
      logic [N_PHYS-1:0][CFG_W:0]     pcfg;
      logic [N_GRP-1:0][N_SI-1:0]     gmask;
      logic [N_GRP-1:0]               gval;
      logic [N_GRP-1:0][2:0]          gfirst;
      logic [N_VIRT-1:0][CFG_W-1:0]   vcfg;
      logic [N_VIRT-1:0]              vstat;
      logic [7:0]                     vidx;
      logic [N_SI-1:0]                in_run;
      logic                           lock;
      logic [N_PHYS-1:0]              sout;
   } sos_state_t;

   localparam sos_state_t ST_RST = '{wait_r: 1'b1, fdiv: FDIV_RST,
                                     default: '0};

endpackage

// ---- src/sos_top.sv ----
// Status output selector: maps internal controller states onto four
// physical status terminals and 256 virtual status bits, register access
// over Avalon-MM with waitrequest.
// Assumes all state inputs are synchronous to clk and already debounced.
//
// Overview of operation
// - At most four convertible terminals serve as physical status outputs.
// - Each status output carries exactly one configured indication function.
// - Bypass output is active exactly while the selected input is bypassed.
// - Mute output is steadily on while the chosen input is muted.
// - Physical mute output flashes when an override could start; virtual never.
// - Mute output is on during a mute-dependent override of its input.
// - Delay output is active while on-delay or off-delay timer runs.
// - Input tracking output shows run or stop of one safety input.
// - Fault output for one input, or for any faulted input.
// - Group output latches the first input to stop until re-armed.
// - Output tracking shows the physical state of one safety output.
// - Fault indication for one safety output, or for any of them.
// - Logical state output reads off already during an off-delay.
// - Function block tracking shows run or stop of one block.
// - Reset-pending output is active while its manual reset is needed.
// - Lockout output is active in any lockout, e.g. energised spare terminal.
// - Up to 256 virtual status outputs, or 64 in small table mode.
// - Virtual tables follow state within 100 ms, others within 1 s.
// - Input state is taken only once its filtering has settled.
// - Sixteen 16-bit status words are readable per door switch chain.
// - Three admin words and 18 data bytes per chained device.
// - Each physical output has selectable polarity, sourcing by default.
//
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps

module sos_top
   import sos_pkg::*;
#(
   parameter int VSO_LAT_CYC_P   = VSO_LAT_CYC,
   parameter int OTHER_LAT_CYC_P = OTHER_LAT_CYC
) (
   input  wire logic                            clk,
   input  wire logic                            sys_rst,
   input  wire logic [11:0]                     avs_address,
   input  wire logic                            avs_read,
   input  wire logic                            avs_write,
   input  wire logic [3:0]                      avs_byteenable,
   input  wire logic [31:0]                     avs_writedata,
   output logic      [31:0]                     avs_readdata,
   output logic                                 avs_waitrequest,
   input  wire logic [N_SI-1:0]                 in_run,
   input  wire logic [N_SI-1:0]                 in_settled,
   input  wire logic [N_SI-1:0]                 in_bypassed,
   input  wire logic [N_SI-1:0]                 in_muted,
   input  wire logic [N_SI-1:0]                 in_mute_ovr,
   input  wire logic [N_SI-1:0]                 in_fault,
   input  wire logic [N_SI-1:0]                 mute_cyc_act,
   input  wire logic [N_SI-1:0]                 mute_sens_blk,
   input  wire logic [N_SO-1:0]                 so_on_dly,
   input  wire logic [N_SO-1:0]                 so_off_dly,
   input  wire logic [N_SO-1:0]                 so_on,
   input  wire logic [N_SO-1:0]                 so_fault,
   input  wire logic [N_SO-1:0]                 so_logic,
   input  wire logic [N_FB-1:0]                 fb_run,
   input  wire logic [N_RST-1:0]                rst_pending,
   input  wire logic                            sys_lockout,
   input  wire logic [N_PHYS-1:0]               term_level,
   input  wire logic [N_GRP-1:0]                group_rearm,
   input  wire logic [CHAIN_WORDS-1:0][15:0]    chain_status,
   input  wire logic [DEV_ADMIN-1:0][15:0]      dev_admin,
   input  wire logic [DEV_BYTES-1:0][7:0]       dev_data,
   output logic      [N_PHYS-1:0]               status_out,
   output logic                                 lockout
);

   sos_state_t      st_q;
   sos_state_t      st_d;
   logic [N_PHYS-1:0] assigned;

   // A terminal counts as assigned once it carries any indication function.
   for (genvar k = 0; k < N_PHYS; k++) begin : g_asg
      assign assigned[k] = st_q.pcfg[k][F_FN+:4] != 4'h0;
   end

   // The virtual scan revisits each entry every N_VIRT cycles.
   if (N_VIRT > VSO_LAT_CYC_P || N_VIRT > OTHER_LAT_CYC_P) begin : g_chk
      $error("Virtual scan period exceeds the latency bound.");
   end

   // Evaluates one configured indication function.
   function automatic logic evalf(input logic [CFG_W-1:0] c,
                                  input logic phys);
      logic [2:0] s;
      logic [1:0] g;
      logic       r;
      s = c[F_SEL+:3];
      g = c[F_GRP+:2];
      r = 1'b0;
      case (sos_fn_t'(c[F_FN+:4]))
         FN_BYPASS: r = in_bypassed[s];
         FN_MUTE: begin
            r = in_muted[s] | in_mute_ovr[s];
            if (phys && !mute_cyc_act[s] && !st_q.in_run[s] &&
                mute_sens_blk[s]) begin
               r = r | st_q.fph;
            end
         end
         FN_DELAY: r = so_on_dly[s[1:0]] | so_off_dly[s[1:0]];
         FN_TRK_IN: r = st_q.in_run[s];
         FN_IN_FLT: r = in_fault[s];
         FN_ANY_IN_FLT: r = |in_fault;
         FN_GROUP: begin
            if (g != 2'h3) begin
               r = st_q.gval[g] && st_q.gfirst[g] == s;
            end
         end
         FN_TRK_OUT: r = so_on[s[1:0]];
         FN_OUT_FLT: r = so_fault[s[1:0]];
         FN_OUT_FLT_ALL: r = |so_fault;
         FN_OUT_LOGIC: r = so_logic[s[1:0]];
         FN_FB: r = fb_run[s];
         FN_RST_WAIT: r = rst_pending[s[1:0]];
         FN_LOCKOUT: r = st_q.lock;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // Register read decode, also used for byte-lane merging on writes.
   function automatic logic [31:0] rd_mux(input logic [11:0] a);
      logic [31:0] r;
      logic [4:0]  b;
      r = 32'h0;
      b = 5'h0;
      if (a == A_CTRL) begin
         r[0] = st_q.v256;
      end else if (a == A_FDIV) begin
         r[FDIV_W-1:0] = st_q.fdiv;
      end else if (a == A_STAT) begin
         r[7:0] = {st_q.gval, st_q.lock, st_q.sout};
      end else if (a >= A_PCFG && a < A_PCFG + 12'h010) begin
         r[CFG_W:0] = st_q.pcfg[a[3:2]];
      end else if (a >= A_GRP && a < A_GRP + 12'h00C) begin
         r[7:0]   = st_q.gmask[a[3:2]];
         r[18:16] = st_q.gfirst[a[3:2]];
         r[19]    = st_q.gval[a[3:2]];
      end else if (a >= A_VSTAT && a < A_VSTAT + 12'h020) begin
         r = st_q.vstat[{a[4:2], 5'h00} +: 32];
      end else if (a >= A_CHAIN && a < A_CHAIN + 12'h040) begin
         r[15:0] = chain_status[a[5:2]];
      end else if (a >= A_ADMIN && a < A_ADMIN + 12'h00C) begin
         r[15:0] = dev_admin[a[3:2]];
      end else if (a >= A_DDATA && a < A_DDATA + 12'h014) begin
         for (int k = 0; k < 4; k++) begin
            b = 5'({a[4:2], 2'b00} + k);
            if (b < 5'(DEV_BYTES)) begin
               r[8*k+:8] = dev_data[b];
            end
         end
      end else if (a >= A_VCFG && a < A_VCFG + 12'h400) begin
         r[CFG_W-1:0] = st_q.vcfg[a[9:2]];
      end
      return r;
   endfunction

   always_comb begin
      logic [N_SI-1:0] fall;
      logic [31:0]     bm;
      logic [31:0]     wv;
      fall = '0;
      bm   = '0;
      wv   = '0;
      st_d = st_q;

      // Bus slave: one wait cycle, then the answer for one cycle.
      st_d.wait_r = 1'b1;
      if ((avs_read || avs_write) && st_q.wait_r) begin
         st_d.wait_r = 1'b0;
         st_d.rdata  = avs_read ? rd_mux(avs_address) : 32'h0;
      end
      if (avs_write && !st_q.wait_r) begin
         for (int i = 0; i < 4; i++) begin
            bm[8*i+:8] = {8{avs_byteenable[i]}};
         end
         wv = (rd_mux(avs_address) & ~bm) | (avs_writedata & bm);
         if (avs_address == A_CTRL) begin
            st_d.v256 = wv[0];
         end else if (avs_address == A_FDIV) begin
            st_d.fdiv = wv[FDIV_W-1:0];
         end else if (avs_address >= A_PCFG &&
                      avs_address < A_PCFG + 12'h010) begin
            st_d.pcfg[avs_address[3:2]] = wv[CFG_W:0];
         end else if (avs_address >= A_GRP &&
                      avs_address < A_GRP + 12'h00C) begin
            st_d.gmask[avs_address[3:2]] = wv[7:0];
         end else if (avs_address >= A_VCFG &&
                      avs_address < A_VCFG + 12'h400) begin
            st_d.vcfg[avs_address[9:2]] = wv[CFG_W-1:0];
         end
      end

      // Flash phase generator with equal on and off halves.
      if (st_q.fcnt >= st_q.fdiv) begin
         st_d.fcnt = '0;
         st_d.fph  = ~st_q.fph;
      end else begin
         st_d.fcnt = FDIV_W'(st_q.fcnt + 1'b1);
      end

      // Input run state is only taken once it has settled.
      for (int i = 0; i < N_SI; i++) begin
         if (in_settled[i]) begin
            st_d.in_run[i] = in_run[i];
         end
      end

      // Group first-off latch; a new stop wins over a re-arm.
      for (int g = 0; g < N_GRP; g++) begin
         fall = st_q.in_run & ~st_d.in_run & st_q.gmask[g];
         if ((!st_q.gval[g] || group_rearm[g]) && |fall) begin
            st_d.gval[g] = 1'b1;
            for (int i = N_SI - 1; i >= 0; i--) begin
               if (fall[i]) begin
                  st_d.gfirst[g] = 3'(i);
               end
            end
         end else if (group_rearm[g]) begin
            st_d.gval[g] = 1'b0;
         end
      end

      st_d.lock = sys_lockout | (|(term_level & ~assigned));

      for (int k = 0; k < N_PHYS; k++) begin
         st_d.sout[k] = evalf(st_q.pcfg[k][CFG_W-1:0], 1'b1) ^
                        st_q.pcfg[k][F_POL];
      end

      // Virtual outputs are refreshed one entry per cycle.
      st_d.vidx = 8'(st_q.vidx + 8'h01);
      if (st_q.v256 || st_q.vidx < 8'(N_VIRT_SMALL)) begin
         st_d.vstat[st_q.vidx] = evalf(st_q.vcfg[st_q.vidx], 1'b0);
      end else begin
         st_d.vstat[st_q.vidx] = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_q <= ST_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign avs_readdata    = st_q.rdata;
   assign avs_waitrequest = st_q.wait_r;
   assign status_out      = st_q.sout;
   assign lockout         = st_q.lock;

   logic [3:0] f0;
   logic [2:0] s0;
   logic       pol0;
   assign f0   = st_q.pcfg[0][F_FN+:4];
   assign s0   = st_q.pcfg[0][F_SEL+:3];
   assign pol0 = st_q.pcfg[0][F_POL];

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_ans;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence

   a_bus_handshake: assert property (s_req |=> s_ans)
      else $error("Bus answer not given after one wait cycle.");
   a_bypass_map: assert property (
      f0 == FN_BYPASS && !pol0 |=> status_out[0] == $past(in_bypassed[s0]))
      else $error("Bypass output does not follow its input.");
   a_mute_flash: assert property (
      f0 == FN_MUTE && !pol0 && !in_muted[s0] && !in_mute_ovr[s0] &&
      !mute_cyc_act[s0] && !st_q.in_run[s0] && mute_sens_blk[s0]
      |=> status_out[0] == $past(st_q.fph))
      else $error("Mute output does not flash.");
   a_delay_map: assert property (
      f0 == FN_DELAY && !pol0 && (so_on_dly[s0[1:0]] || so_off_dly[s0[1:0]])
      |=> status_out[0])
      else $error("Delay output not active.");
   a_any_fault: assert property (
      f0 == FN_ANY_IN_FLT && pol0 && |in_fault |=> !status_out[0])
      else $error("Any-fault output not active.");
   a_group_hold: assert property (
      st_q.gval[0] && !group_rearm[0]
      |=> st_q.gval[0] && $stable(st_q.gfirst[0]))
      else $error("Group latch changed without re-arm.");
   a_lockout_term: assert property (
      |(term_level & ~assigned) |=> lockout)
      else $error("Energised spare terminal gave no lockout.");
   a_polarity_inv: assert property (
      f0 == FN_LOCKOUT && pol0 |=> status_out[0] == !$past(lockout))
      else $error("Inverted polarity not applied.");
   a_virt_limit: assert property (
      !st_q.v256 && st_q.vidx >= 8'h40 |=> !st_q.vstat[$past(st_q.vidx)])
      else $error("Virtual entry beyond small table is active.");
   a_scan_step: assert property (
      1'b1 |=> st_q.vidx == 8'($past(st_q.vidx) + 8'h01))
      else $error("Virtual scan index did not advance.");
   a_settle_hold: assert property (
      !in_settled[0] |=> $stable(st_q.in_run[0]))
      else $error("Unsettled input state was taken.");

endmodule
